// file: bench/bit_pin_src.sv
/*
  External pulse, trigger and gate source for the three timer pins.
  Assumes commands change at the falling edge of mclk_i.
*/
`timescale 1ns/1ps
module bit_pin_src (
  // Clock
  input  wire logic       mclk_i,
  // Commands per instance
  input  wire logic [2:0] go_i,
  input  wire logic [2:0] hold_i,
  // Pins
  output logic      [2:0] pin_o
);
  logic [2:0][2:0] ph_q = '0;
  // ----------------------------------------
  // Pulse train
  // ----------------------------------------
  // pulse source, one rising edge per 8 cycles
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 3; i++) begin
      ph_q[i] <= go_i[i] ? ph_q[i] + 3'h1 : 3'h0;
    end
  end
  // level source for gate and trigger
  assign pin_o = hold_i | (go_i & {ph_q[2][2], ph_q[1][2], ph_q[0][2]});
endmodule

// file: bench/testbench.sv
/*
  Self-checking bench for the three-instance interval timer.
  Assumes the pin source model drives the trigger pins.
*/
`timescale 1ns/1ps
module testbench;
  logic             mclk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic [2:0]       en = '0, clr = '0, uie = '0, tie = '0, go = '0;
  logic [2:0]       pol = 3'h4, hold = 3'h4;
  logic [2:0][1:0]  mode = '0;
  logic [2:0][15:0] psc = '0, rld = '0;
  logic [2:0]       pin, tp, tn, run, uirq, tirq;
  logic [2:0][15:0] cnt;
  int               failures = 0;
  int               checks = 0;

  always #4 mclk_i = ~mclk_i;

  bit_pin_src bit_pin_src_i (.mclk_i(mclk_i), .go_i(go), .hold_i(hold), .pin_o(pin));
  bit_timer bit_timer_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .enable_i(en), .mode_i(mode),
    .psc_i(psc), .reload_i(rld), .trig_pol_i(pol), .cnt_clr_i(clr), .upd_irq_en_i(uie),
    .trg_irq_en_i(tie), .ext_trigger_in_i(pin), .toggle_out_pos_o(tp), .toggle_out_neg_o(tn),
    .count_o(cnt), .running_o(run), .update_irq_o(uirq), .trigger_irq_o(tirq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task stop_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_walk;
    int k;
    uie[0] = 1'b1;
    rld[0] = 16'h0002;
    en[0]  = 1'b1;
    k = 0;
    while (run[0] !== 1'b1 && k < 8) begin
      tick(1);
      k++;
    end
    chk(k, 1);
    tick(1); chk(cnt[0], 16'h0001);
    tick(1); chk(cnt[0], 16'h0002);
    tick(1); chk({uirq[0], cnt[0]}, 17'h10000);
    chk({tp[0], tn[0]}, 2'h2);
    chk(cnt[1], 16'h0000);
    tick(1); chk({uirq[0], cnt[0]}, 17'h00001);
    en[0] = 1'b0;
    tick(2);
    $display("walk done");
  endtask

  task t_psc;
    int k;
    psc[0] = 16'h0002;
    rld[0] = 16'h0001;
    en[0]  = 1'b1;
    k = 0;
    while (uirq[0] !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    k = 0;
    do begin
      tick(1);
      k++;
    end while (uirq[0] !== 1'b1 && k < 40);
    chk(k, 6);
    rld[0] = 16'hFFFF;
    tick(5);
    clr[0] = 1'b1;
    tick(1);
    clr[0] = 1'b0;
    chk(cnt[0], 16'h0000);
    en[0] = 1'b0;
    $display("prescale and clear done");
  endtask

  task t_ext;
    int n;
    logic prev;
    mode[1] = 2'h1;
    rld[1]  = 16'hFFFF;
    en[1]   = 1'b1;
    tick(4);
    go[1] = 1'b1;
    n = 0;
    prev = 1'b0;
    repeat (64) begin
      tick(1);
      if (pin[1] && !prev) n++;
      prev = pin[1];
    end
    go[1] = 1'b0;
    tick(8);
    chk(cnt[1], n);
    en[1] = 1'b0;
    $display("external done");
  endtask

  task t_gate;
    logic [15:0] c;
    mode[1] = 2'h3;
    clr[1] = 1'b1;
    tick(1);
    clr[1] = 1'b0;
    en[1] = 1'b1;
    hold[1] = 1'b1;
    tick(20);
    chk(cnt[1] != 16'h0, 1);
    hold[1] = 1'b0;
    tick(6);
    c = cnt[1];
    tick(10);
    chk(cnt[1], c);
    chk(run[1], 0);
    en[1] = 1'b0;
    $display("gated done");
  endtask

  task t_trig;
    int k;
    mode[2] = 2'h2;
    rld[2] = 16'hFFFF;
    tie[2] = 1'b1;
    en[2] = 1'b1;
    tick(8);
    chk(run[2], 0);
    hold[2] = 1'b0;
    k = 0;
    while (tirq[2] !== 1'b1 && k < 10) begin
      tick(1);
      k++;
    end
    chk(tirq[2], 1);
    chk(k, 3);
    hold[2] = 1'b1;
    tick(6);
    chk(run[2], 1);
    chk(cnt[2] != 16'h0, 1);
    en[2] = 1'b0;
    $display("trigger done");
  endtask

  // ----------------------------------------
  // Main and watchdog
  // ----------------------------------------
  initial begin
    tick(16);
    rst_n_i = 1'b1;
    tick(2);
    t_walk;
    t_psc;
    t_ext;
    t_gate;
    t_trig;
    stop_test;
  end

  // Whole run needs about 170 cycles; limit is 4000 cycles, over twenty times that
  initial begin
    #32000;
    failures++;
    stop_test;
  end
endmodule

// file: common/bit_defs.svh
/*
  Constants for the three-instance basic interval timer: mode codes, widths,
  reset values and pin synchroniser depth.
  Assumes inclusion by bare name from the package; the design files only use its macros.
*/
`ifndef BIT_DEFS_SVH
`define BIT_DEFS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define BIT_CNT_W      16
`define BIT_PSC_W      16
`define BIT_NUM_INST   3
`define BIT_SYNC_DEPTH 2

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define BIT_MODE_INT   2'h0
`define BIT_MODE_EXT   2'h1
`define BIT_MODE_TRIG  2'h2
`define BIT_MODE_GATE  2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BIT_CNT_RST    16'h0000
`define BIT_TOG_RST    1'b0

`endif

// file: common/bit_pkg.sv
/*
  Types for the basic interval timer.
  Assumes bit_defs.svh is on the include path.
*/
`include "bit_defs.svh"
package bit_pkg;
  typedef enum logic [1:0] {
    BIT_INTERNAL = 2'b00,
    BIT_EXTERNAL = 2'b01,
    BIT_TRIGGER  = 2'b10,
    BIT_GATED    = 2'b11
  } bit_mode_t;
endpackage

// file: rtl/bit_channel.sv
/*
  One basic interval timer instance: pin synchroniser, prescaler, up counter
  with auto-reload, mode control and toggle pair.
  Assumes one clock mclk_i; ext pin is asynchronous to it.
*/
`timescale 1ns/1ps
module bit_channel
  import bit_pkg::*;
#(
  parameter int CNT_W = `BIT_CNT_W,
  parameter int PSC_W = `BIT_PSC_W
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             enable_i,
  input  wire bit_mode_t        mode_i,
  input  wire logic [PSC_W-1:0] psc_i,
  input  wire logic [CNT_W-1:0] reload_i,
  input  wire logic             trig_pol_i,
  input  wire logic             cnt_clr_i,
  // Pin
  input  wire logic             ext_trigger_in_i,
  // Status and pins
  output logic [CNT_W-1:0]      count_o,
  output logic                  update_o,
  output logic                  trigger_o,
  output logic                  running_o,
  output logic                  toggle_out_pos_o,
  output logic                  toggle_out_neg_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic             sync1_q, sync2_q, prev_q;
  logic             sync1_d, sync2_d, prev_d;
  logic [PSC_W-1:0] psc_q, psc_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             run_q, run_d;
  logic             tog_q, tog_d;
  logic             upd_q, upd_d;
  logic             trg_q, trg_d;
  logic             lvl;
  logic             edge_s;
  logic             src_tick;
  logic             tick;

  // ----------------------------------------
  // Next-state
  // ----------------------------------------
  always_comb begin
    sync1_d = ext_trigger_in_i;
    sync2_d = sync1_q;
    // Only the second stage feeds logic
    lvl     = sync2_q ^ trig_pol_i;
    // Edge on raw synced pin; reset zeros fake a rising edge if the pin is high, never a falling one
    prev_d  = sync2_q;
    edge_s  = trig_pol_i ? (~sync2_q & prev_q) : (sync2_q & ~prev_q);
    run_d   = run_q;
    unique case (mode_i)
      BIT_INTERNAL: run_d = enable_i;
      BIT_EXTERNAL: run_d = enable_i;
      BIT_TRIGGER:  run_d = enable_i & (run_q | edge_s);
      BIT_GATED:    run_d = enable_i & lvl;
    endcase
    src_tick = (mode_i == BIT_EXTERNAL) ? edge_s : 1'b1;
    psc_d    = psc_q;
    tick     = 1'b0;
    if (run_q & src_tick) begin
      if (psc_q >= psc_i) begin
        psc_d = '0;
        tick  = 1'b1;
      end else begin
        psc_d = psc_q + 1'b1;
      end
    end
    cnt_d = cnt_q;
    tog_d = tog_q;
    upd_d = 1'b0;
    if (tick) begin
      if (cnt_q >= reload_i) begin
        cnt_d = '0;
        upd_d = 1'b1;
        tog_d = ~tog_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    if (cnt_clr_i) begin
      cnt_d = '0;
      psc_d = '0;
    end
    trg_d = edge_s & enable_i & (mode_i == BIT_TRIGGER);
    if (!enable_i) begin
      psc_d = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      psc_q   <= '0;
      cnt_q   <= `BIT_CNT_RST;
      run_q   <= 1'b0;
      tog_q   <= `BIT_TOG_RST;
      upd_q   <= 1'b0;
      trg_q   <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      psc_q   <= psc_d;
      cnt_q   <= cnt_d;
      run_q   <= run_d;
      tog_q   <= tog_d;
      upd_q   <= upd_d;
      trg_q   <= trg_d;
    end
  end

  assign toggle_out_pos_o = tog_q;
  assign toggle_out_neg_o = ~tog_q;
  assign count_o          = cnt_q;
  assign update_o         = upd_q;
  assign trigger_o        = trg_q;
  assign running_o        = run_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  AST_WRAP_ZERO: assert property (update_o |-> count_o == '0)
    else $error("update without wrap to zero");
  AST_CLEAR: assert property (cnt_clr_i |=> count_o == '0)
    else $error("clear did not zero counter");
  AST_UP_ONLY: assert property (!$past(cnt_clr_i) && !update_o && $changed(count_o)
                                |-> count_o == $past(count_o) + 1'b1)
    else $error("counter moved other than up by one");
  AST_PSC_ONE: assert property (psc_i == '0 && run_q && mode_i == BIT_INTERNAL && !cnt_clr_i
                                && count_o < reload_i && $stable(psc_i) && $stable(mode_i)
                                |=> count_o == $past(count_o) + 1'b1)
    else $error("divide by one missed a tick");
  AST_GATE: assert property (mode_i == BIT_GATED && $stable(mode_i) && !run_q && !cnt_clr_i
                             |=> $stable(count_o))
    else $error("gated counter moved while closed");
  AST_TRIG_IRQ: assert property (trigger_o |-> $past(mode_i) == BIT_TRIGGER)
    else $error("trigger event outside trigger mode");
  AST_TOG_PAIR: assert property ($changed(toggle_out_pos_o)
                                 |-> update_o && toggle_out_neg_o != toggle_out_pos_o)
    else $error("toggle moved without update or pair not complementary");
  AST_UPD_TOG: assert property (update_o |-> toggle_out_pos_o != $past(toggle_out_pos_o))
    else $error("update without toggle");

  COV_UPDATE: cover property (update_o);
  COV_TRIGGER: cover property (trigger_o ##[1:20] update_o);
  COV_GATE: cover property (mode_i == BIT_GATED && run_q ##1 !run_q);
  COV_EXT: cover property (mode_i == BIT_EXTERNAL && tick);

endmodule

// file: rtl/bit_timer.sv
/*
  Three independent basic interval timers with per-instance control ports,
  update and trigger interrupt requests, toggle pairs and trigger pins.
  Assumes control inputs come from logic on mclk_i; pins are asynchronous.
*/
`timescale 1ns/1ps
module bit_timer
  import bit_pkg::*;
#(
  parameter int NUM   = `BIT_NUM_INST,
  parameter int CNT_W = `BIT_CNT_W,
  parameter int PSC_W = `BIT_PSC_W
) (
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  // Control per instance
  input  wire logic [NUM-1:0]            enable_i,
  input  wire logic [NUM-1:0][1:0]       mode_i,
  input  wire logic [NUM-1:0][PSC_W-1:0] psc_i,
  input  wire logic [NUM-1:0][CNT_W-1:0] reload_i,
  input  wire logic [NUM-1:0]            trig_pol_i,
  input  wire logic [NUM-1:0]            cnt_clr_i,
  input  wire logic [NUM-1:0]            upd_irq_en_i,
  input  wire logic [NUM-1:0]            trg_irq_en_i,
  // Pins
  input  wire logic [NUM-1:0]            ext_trigger_in_i,
  output logic      [NUM-1:0]            toggle_out_pos_o,
  output logic      [NUM-1:0]            toggle_out_neg_o,
  // Status
  output logic      [NUM-1:0][CNT_W-1:0] count_o,
  output logic      [NUM-1:0]            running_o,
  output logic      [NUM-1:0]            update_irq_o,
  output logic      [NUM-1:0]            trigger_irq_o
);

  logic [NUM-1:0] upd;
  logic [NUM-1:0] trg;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  // independent copies
  for (genvar g = 0; g < NUM; g++) begin : g_inst
    bit_channel #(
      .CNT_W (CNT_W),
      .PSC_W (PSC_W)
    ) u_ch (
      .mclk_i           (mclk_i),
      .rst_n_i          (rst_n_i),
      .enable_i         (enable_i[g]),
      .mode_i           (bit_mode_t'(mode_i[g])),
      .psc_i            (psc_i[g]),
      .reload_i         (reload_i[g]),
      .trig_pol_i       (trig_pol_i[g]),
      .cnt_clr_i        (cnt_clr_i[g]),
      .ext_trigger_in_i (ext_trigger_in_i[g]),
      .count_o          (count_o[g]),
      .update_o         (upd[g]),
      .trigger_o        (trg[g]),
      .running_o        (running_o[g]),
      .toggle_out_pos_o (toggle_out_pos_o[g]),
      .toggle_out_neg_o (toggle_out_neg_o[g])
    );

    AST_IRQ_GATE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
                                   update_irq_o[g] |-> upd_irq_en_i[g] && count_o[g] == '0)
      else $error("update request without enable or wrap");
    AST_TRG_RUN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
                                  trigger_irq_o[g] |-> trg_irq_en_i[g] && running_o[g])
      else $error("trigger request without enable or start");
  end

  assign update_irq_o  = upd & upd_irq_en_i;
  assign trigger_irq_o = trg & trg_irq_en_i;

endmodule
